/* src/vbd_pkg.sv */
`default_nettype none
package vbd_pkg;
   // Register offsets (byte addresses on the register port)
   localparam logic [7:0] VBD_OFF_STATUS = 8'h00;
   localparam logic [7:0] VBD_OFF_COMMAND = 8'h04;
   localparam logic [7:0] VBD_OFF_SLICE_QS = 8'h08;
   localparam logic [7:0] VBD_OFF_PICTURE = 8'h0c;
   localparam logic [7:0] VBD_OFF_CONTROL = 8'h10;

   // decoder_status fields
   localparam int VBD_ST_DONE_BIT = 0;
   localparam int VBD_ST_START_BIT = 1;
   localparam int VBD_ST_ERROR_BIT = 2;
   localparam int VBD_ST_BUSY_BIT = 3;
   localparam int VBD_ST_RESETTING_BIT = 4;

   // decoder_command fields
   localparam int VBD_CMD_CODE_LSB = 0;
   localparam int VBD_CMD_CODE_W = 4;
   localparam int VBD_CMD_COUNT_LSB = 8;
   localparam int VBD_CMD_COUNT_W = 8;

   // picture_parameters fields, first field in the top bits
   localparam int VBD_PP_TYPE_LSB = 30;
   localparam int VBD_PP_STRUCT_LSB = 28;
   localparam int VBD_PP_FRAME_ONLY_BIT = 27;
   localparam int VBD_PP_INTRA_TBL_BIT = 26;
   localparam int VBD_PP_CONCEAL_BIT = 25;
   localparam int VBD_PP_STD_BIT = 18;
   localparam int VBD_PP_FH_LSB = 12;
   localparam int VBD_PP_FV_LSB = 8;
   localparam int VBD_PP_BH_LSB = 4;
   localparam int VBD_PP_BV_LSB = 0;
   localparam logic [31:0] VBD_PP_WRITE_MASK = 32'hfe04ffff;

   // control fields
   localparam int VBD_CTL_IRQ_EN_BIT = 0;
   localparam int VBD_CTL_BIG_END_BIT = 1;

   // Reset values
   localparam logic [31:0] VBD_PP_RESET = 32'h00000000;
   localparam logic [4:0] VBD_QS_RESET = 5'h00;
   localparam logic [1:0] VBD_CTL_RESET = 2'h0;

   localparam int VBD_QS_W = 5;
   localparam int VBD_IRQ_SOURCE = 14;

   typedef enum logic [3:0] {
      VBD_CMD_NONE = 4'h0,
      VBD_CMD_SHIFT = 4'h1,
      VBD_CMD_PARSE = 4'h2,
      VBD_CMD_SEARCH = 4'h3,
      VBD_CMD_RESET = 4'h4,
      VBD_CMD_FLUSH = 4'h8
   } vbd_cmd_e;

   typedef enum logic [1:0] {
      VBD_IDLE = 2'b00,
      VBD_RUN = 2'b01,
      VBD_DRAIN = 2'b11,
      VBD_CLEAR = 2'b10
   } vbd_state_e;
endpackage
`default_nettype wire

/* src/vbd_sticky.sv */
`default_nettype none
module vbd_sticky (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic set_i,
   input wire logic w1c_i,
   input wire logic sreset_i,
   output logic q_o
);
   // Full reset beats everything; a new event beats a software clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_o <= 1'b0;
      end else if (sreset_i) begin
         q_o <= 1'b0;
      end else if (set_i) begin
         q_o <= 1'b1;
      end else if (w1c_i) begin
         q_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* src/vbd_ctrl.sv */
`default_nettype none
module vbd_ctrl
   import vbd_pkg::*;
#(
   parameter int QS_W = vbd_pkg::VBD_QS_W,
   parameter int PEND_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   // Parsing datapath status
   input wire logic dp_error_i,
   input wire logic dp_start_code_present_i,
   input wire logic dp_start_code_i,
   input wire logic dp_cmd_done_i,
   input wire logic dp_halt_i,
   input wire logic mb_header_i,
   input wire logic mb_qs_valid_i,
   input wire logic [QS_W-1:0] mb_qs_i,
   // Memory-bus master status
   input wire logic [PEND_W-1:0] bus_pending_i,
   // Parsing datapath control
   output logic cmd_start_o,
   output vbd_pkg::vbd_cmd_e cmd_code_o,
   output logic [7:0] cmd_count_o,
   output logic flush_start_o,
   output logic bus_start_allow_o,
   output logic buf_clear_o,
   output logic [QS_W-1:0] mbh_qscale_o,
   output logic [1:0] picture_type_o,
   output logic [1:0] picture_structure_o,
   output logic standard_select_o,
   output logic intra_table_select_o,
   output logic concealment_flag_o,
   output logic frame_only_flag_o,
   output logic parse_mb_pred_type_o,
   output logic [3:0] fwd_horiz_range_o,
   output logic [3:0] fwd_vert_range_o,
   output logic [3:0] bwd_horiz_range_o,
   output logic [3:0] bwd_vert_range_o,
   output logic big_endian_o,
   output logic irq_o
);
   import vbd_pkg::*;

   vbd_state_e state_reg;
   vbd_state_e state_next;
   logic [QS_W-1:0] slice_quant_scale_reg;
   logic [31:0] picture_parameters_reg;
   logic [1:0] control_reg;
   logic [15:0] command_reg;
   logic done_flag;
   logic start_code_flag;
   logic error_flag;
   logic soft_clear;
   logic wr_status;
   logic wr_command;
   logic wr_slice_qs;
   logic wr_picture;
   logic wr_control;
   logic [3:0] wr_code;
   logic cmd_accept;
   logic reset_cmd;
   logic set_start_code;
   logic [31:0] status_word;
   logic [31:0] rdata_next;

   // Address decode
   always_comb begin
      wr_status = 1'b0;
      wr_command = 1'b0;
      wr_slice_qs = 1'b0;
      wr_picture = 1'b0;
      wr_control = 1'b0;
      if (!reg_wr_i) begin
         wr_status = 1'b0;
      end else if (reg_addr_i == VBD_OFF_STATUS) begin
         wr_status = 1'b1;
      end else if (reg_addr_i == VBD_OFF_COMMAND) begin
         wr_command = 1'b1;
      end else if (reg_addr_i == VBD_OFF_SLICE_QS) begin
         wr_slice_qs = 1'b1;
      end else if (reg_addr_i == VBD_OFF_PICTURE) begin
         wr_picture = 1'b1;
      end else if (reg_addr_i == VBD_OFF_CONTROL) begin
         wr_control = 1'b1;
      end
   end

   assign wr_code = reg_wdata_i[VBD_CMD_CODE_LSB +: VBD_CMD_CODE_W];
   // Commands are taken only while halted; reset is also taken mid-command
   assign reset_cmd = wr_command && (wr_code == VBD_CMD_RESET) && (state_reg != VBD_DRAIN)
                      && (state_reg != VBD_CLEAR);
   assign cmd_accept = wr_command && (state_reg == VBD_IDLE) && (wr_code != VBD_CMD_RESET)
                       && (wr_code != VBD_CMD_NONE);
   // Full clear lands the cycle after the bus has gone quiet
   assign soft_clear = (state_reg == VBD_DRAIN) && (bus_pending_i == '0);

   // Command sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         VBD_IDLE: begin
            if (reset_cmd) begin
               state_next = VBD_DRAIN;
            end else if (cmd_accept) begin
               state_next = VBD_RUN;
            end
         end
         VBD_RUN: begin
            if (reset_cmd) begin
               state_next = VBD_DRAIN;
            end else if (dp_cmd_done_i || dp_halt_i) begin
               state_next = VBD_IDLE;
            end
         end
         VBD_DRAIN: begin
            // Started bus transactions are never cut short
            if (bus_pending_i == '0) begin
               state_next = VBD_CLEAR;
            end
         end
         VBD_CLEAR: begin
            state_next = VBD_IDLE;
         end
         default: begin
            state_next = VBD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= VBD_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // No new bus transaction may start once a reset is pending
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_start_allow_o <= 1'b1;
      end else begin
         bus_start_allow_o <= (state_next != VBD_DRAIN) && (state_next != VBD_CLEAR);
      end
   end

   // Buffers emptied during the cycle after the drain ends
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_clear_o <= 1'b0;
      end else begin
         buf_clear_o <= soft_clear;
      end
   end

   // decoder_command register and datapath strobes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         command_reg <= 16'h0000;
      end else if (soft_clear) begin
         command_reg <= 16'h0000;
      end else if (cmd_accept || reset_cmd) begin
         command_reg <= reg_wdata_i[15:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_start_o <= 1'b0;
         flush_start_o <= 1'b0;
         cmd_code_o <= VBD_CMD_NONE;
         cmd_count_o <= 8'h00;
      end else begin
         cmd_start_o <= cmd_accept;
         // Datapath writes out only valid bytes using byte enables
         flush_start_o <= cmd_accept && (wr_code == VBD_CMD_FLUSH);
         if (soft_clear) begin
            cmd_code_o <= VBD_CMD_NONE;
            cmd_count_o <= 8'h00;
         end else if (cmd_accept) begin
            cmd_code_o <= vbd_cmd_e'(wr_code);
            cmd_count_o <= reg_wdata_i[VBD_CMD_COUNT_LSB +: VBD_CMD_COUNT_W];
         end
      end
   end

   // Status flags
   assign set_start_code = dp_start_code_i || (dp_error_i && dp_start_code_present_i);

   vbd_sticky u_done (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .set_i(dp_cmd_done_i && (state_reg == VBD_RUN)),
      .w1c_i(cmd_accept),
      .sreset_i(soft_clear),
      .q_o(done_flag)
   );

   vbd_sticky u_start_code (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .set_i(set_start_code),
      .w1c_i(wr_status && reg_wdata_i[VBD_ST_START_BIT]),
      .sreset_i(soft_clear),
      .q_o(start_code_flag)
   );

   // An error leaves the output buffers untouched until a flush command
   vbd_sticky u_error (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .set_i(dp_error_i),
      .w1c_i(wr_status && reg_wdata_i[VBD_ST_ERROR_BIT]),
      .sreset_i(soft_clear),
      .q_o(error_flag)
   );

   // Interrupt held as a level until the error flag is cleared
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= error_flag && control_reg[VBD_CTL_IRQ_EN_BIT];
      end
   end

   // slice_quant_scale and macroblock override
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slice_quant_scale_reg <= VBD_QS_RESET;
      end else if (soft_clear) begin
         slice_quant_scale_reg <= VBD_QS_RESET;
      end else if (wr_slice_qs) begin
         slice_quant_scale_reg <= reg_wdata_i[QS_W-1:0];
      end
   end

   // Slice code stands until a macroblock code replaces it; a new slice write restores it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mbh_qscale_o <= VBD_QS_RESET;
      end else if (soft_clear) begin
         mbh_qscale_o <= VBD_QS_RESET;
      end else if (wr_slice_qs) begin
         mbh_qscale_o <= reg_wdata_i[QS_W-1:0];
      end else if (mb_header_i && mb_qs_valid_i) begin
         mbh_qscale_o <= mb_qs_i;
      end
   end

   // picture_parameters; reserved bits are not stored
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         picture_parameters_reg <= VBD_PP_RESET;
      end else if (soft_clear) begin
         picture_parameters_reg <= VBD_PP_RESET;
      end else if (wr_picture) begin
         picture_parameters_reg <= reg_wdata_i & VBD_PP_WRITE_MASK;
      end
   end

   // Field outputs, registered from the same write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         picture_type_o <= 2'h0;
         picture_structure_o <= 2'h0;
         standard_select_o <= 1'b0;
         intra_table_select_o <= 1'b0;
         concealment_flag_o <= 1'b0;
         frame_only_flag_o <= 1'b0;
         parse_mb_pred_type_o <= 1'b0;
         fwd_horiz_range_o <= 4'h0;
         fwd_vert_range_o <= 4'h0;
         bwd_horiz_range_o <= 4'h0;
         bwd_vert_range_o <= 4'h0;
      end else if (soft_clear) begin
         picture_type_o <= 2'h0;
         picture_structure_o <= 2'h0;
         standard_select_o <= 1'b0;
         intra_table_select_o <= 1'b0;
         concealment_flag_o <= 1'b0;
         frame_only_flag_o <= 1'b0;
         parse_mb_pred_type_o <= 1'b0;
         fwd_horiz_range_o <= 4'h0;
         fwd_vert_range_o <= 4'h0;
         bwd_horiz_range_o <= 4'h0;
         bwd_vert_range_o <= 4'h0;
      end else if (wr_picture) begin
         picture_type_o <= reg_wdata_i[VBD_PP_TYPE_LSB +: 2];
         picture_structure_o <= reg_wdata_i[VBD_PP_STRUCT_LSB +: 2];
         standard_select_o <= reg_wdata_i[VBD_PP_STD_BIT];
         intra_table_select_o <= reg_wdata_i[VBD_PP_INTRA_TBL_BIT];
         // Concealment vectors only exist in second-generation syntax
         concealment_flag_o <= reg_wdata_i[VBD_PP_CONCEAL_BIT] && reg_wdata_i[VBD_PP_STD_BIT];
         frame_only_flag_o <= reg_wdata_i[VBD_PP_FRAME_ONLY_BIT];
         parse_mb_pred_type_o <= reg_wdata_i[VBD_PP_STD_BIT] && !reg_wdata_i[VBD_PP_FRAME_ONLY_BIT];
         fwd_horiz_range_o <= reg_wdata_i[VBD_PP_FH_LSB +: 4];
         fwd_vert_range_o <= reg_wdata_i[VBD_PP_FV_LSB +: 4];
         bwd_horiz_range_o <= reg_wdata_i[VBD_PP_BH_LSB +: 4];
         bwd_vert_range_o <= reg_wdata_i[VBD_PP_BV_LSB +: 4];
      end
   end

   // Control: interrupt enable and byte order
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         control_reg <= VBD_CTL_RESET;
      end else if (soft_clear) begin
         control_reg <= VBD_CTL_RESET;
      end else if (wr_control) begin
         control_reg <= reg_wdata_i[1:0];
      end
   end

   // Byte order steers input unpacking and output packing alike
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         big_endian_o <= 1'b0;
      end else if (soft_clear) begin
         big_endian_o <= 1'b0;
      end else if (wr_control) begin
         big_endian_o <= reg_wdata_i[VBD_CTL_BIG_END_BIT];
      end
   end

   // Busy bit lets software check idleness before block power-down;
   // state after a power-down while busy is not defined
   always_comb begin
      status_word = 32'h00000000;
      status_word[VBD_ST_DONE_BIT] = done_flag;
      status_word[VBD_ST_START_BIT] = start_code_flag;
      status_word[VBD_ST_ERROR_BIT] = error_flag;
      status_word[VBD_ST_BUSY_BIT] = (state_reg != VBD_IDLE);
      status_word[VBD_ST_RESETTING_BIT] = (state_reg == VBD_DRAIN) || (state_reg == VBD_CLEAR);
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = 32'h00000000;
      if (reg_addr_i == VBD_OFF_STATUS) begin
         rdata_next = status_word;
      end else if (reg_addr_i == VBD_OFF_COMMAND) begin
         rdata_next = {16'h0000, command_reg};
      end else if (reg_addr_i == VBD_OFF_SLICE_QS) begin
         rdata_next = {{(32 - QS_W){1'b0}}, slice_quant_scale_reg};
      end else if (reg_addr_i == VBD_OFF_PICTURE) begin
         rdata_next = picture_parameters_reg;
      end else if (reg_addr_i == VBD_OFF_CONTROL) begin
         rdata_next = {30'h00000000, control_reg};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_next;
      end
   end
endmodule
`default_nettype wire

/* tb/vbd_ctrl_props.sv */
`default_nettype none
module vbd_ctrl_props
   import vbd_pkg::*;
#(
   parameter int QS_W = 5,
   parameter int PEND_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic dp_error_i,
   input wire logic mb_header_i,
   input wire logic mb_qs_valid_i,
   input wire logic [QS_W-1:0] mb_qs_i,
   input wire logic [PEND_W-1:0] bus_pending_i,
   input wire logic cmd_start_o,
   input wire vbd_pkg::vbd_cmd_e cmd_code_o,
   input wire logic flush_start_o,
   input wire logic bus_start_allow_o,
   input wire logic buf_clear_o,
   input wire logic [QS_W-1:0] mbh_qscale_o,
   input wire logic [1:0] picture_type_o,
   input wire logic [1:0] picture_structure_o,
   input wire logic standard_select_o,
   input wire logic intra_table_select_o,
   input wire logic concealment_flag_o,
   input wire logic frame_only_flag_o,
   input wire logic parse_mb_pred_type_o,
   input wire logic [3:0] fwd_horiz_range_o,
   input wire logic [3:0] fwd_vert_range_o,
   input wire logic [3:0] bwd_horiz_range_o,
   input wire logic [3:0] bwd_vert_range_o,
   input wire logic big_endian_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic qs_wr;
   logic pp_wr;
   logic mbq;
   // Writes during a software reset are left out; all but those in the CLEAR cycle are lost to the clear
   assign qs_wr = reg_wr_i && reg_addr_i == VBD_OFF_SLICE_QS && bus_start_allow_o;
   assign pp_wr = reg_wr_i && reg_addr_i == VBD_OFF_PICTURE && bus_start_allow_o;
   assign mbq = mb_header_i && mb_qs_valid_i && bus_start_allow_o;
   qs_write_a: assert property (
      qs_wr && !mbq |=> mbh_qscale_o == $past(reg_wdata_i[QS_W-1:0])) else $error("slice code not emitted");
   mb_override_a: assert property (
      mbq && !qs_wr |=> mbh_qscale_o == $past(mb_qs_i)) else $error("macroblock code not taken");
   pic_fields_a: assert property (
      pp_wr |=> {picture_type_o, picture_structure_o, frame_only_flag_o, intra_table_select_o, standard_select_o,
      fwd_horiz_range_o, fwd_vert_range_o, bwd_horiz_range_o, bwd_vert_range_o}
      == {$past(reg_wdata_i[31:26]), $past(reg_wdata_i[18]), $past(reg_wdata_i[15:0])}) else $error("picture fields");
   conceal_std_a: assert property (
      pp_wr |=> concealment_flag_o == ($past(reg_wdata_i[25]) && $past(reg_wdata_i[18])))
      else $error("concealment flag");
   frame_only_a: assert property (
      parse_mb_pred_type_o == (standard_select_o && !frame_only_flag_o)) else $error("prediction type parse");
   flush_code_a: assert property (
      flush_start_o |-> cmd_start_o && cmd_code_o == VBD_CMD_FLUSH) else $error("flush without command");
   no_err_flush_a: assert property (
      dp_error_i && !reg_wr_i |=> !flush_start_o) else $error("error flushed buffers");
   drain_wait_a: assert property (
      buf_clear_o |-> $past(bus_pending_i) == '0 && !$past(bus_start_allow_o)) else $error("reset before drain");
   drain_done_a: assert property (
      $fell(bus_start_allow_o) && bus_pending_i == '0 |=> buf_clear_o) else $error("late clear");
   clear_zero_a: assert property (
      buf_clear_o |-> mbh_qscale_o == '0 && picture_type_o == '0 && fwd_horiz_range_o == '0 && !big_endian_o
      ##1 !irq_o) else $error("registers not cleared");
   irq_hold_a: assert property (
      irq_o && !reg_wr_i && !$past(reg_wr_i) && bus_start_allow_o && $past(bus_start_allow_o) |=> irq_o)
      else $error("interrupt level dropped");
   cover property (buf_clear_o);
   cover property (flush_start_o);
   cover property (irq_o);
   cover property (mbq);
endmodule
`default_nettype wire

/* tb/vbd_partner.sv */
`default_nettype none
module vbd_partner (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_start_i,
   input wire logic allow_i,
   input wire logic [3:0] burst_i,
   input wire logic [3:0] lat_i,
   output logic [3:0] pending_o,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] tick;
   logic [2:0] dly;
   // New transfers start only while allowed; started ones run to the end unless an allowed new burst reloads the count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_o <= '0;
         tick <= '0;
      end else if (burst_i != '0 && allow_i) begin
         pending_o <= burst_i;
      end else if (pending_o != '0) begin
         tick <= (tick >= lat_i) ? 4'h0 : tick + 4'h1;
         if (tick >= lat_i) begin
            pending_o <= pending_o - 4'h1;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dly <= '0;
         done_o <= 1'b0;
      end else begin
         dly <= cmd_start_i ? 3'h3 : (dly != '0 ? dly - 3'h1 : dly);
         done_o <= (dly == 3'h1);
      end
   end
endmodule
`default_nettype wire

/* tb/vbd_ctrl_tb_top.sv */
`default_nettype none
module vbd_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import vbd_pkg::*;
   logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, dp_error_i, dp_start_code_present_i, dp_start_code_i, dp_halt_i;
   logic dp_cmd_done_i, mb_header_i, mb_qs_valid_i, cmd_start_o, flush_start_o, bus_start_allow_o, buf_clear_o;
   logic standard_select_o, intra_table_select_o, concealment_flag_o, frame_only_flag_o, parse_mb_pred_type_o;
   logic big_endian_o, irq_o;
   logic [7:0] reg_addr_i, cmd_count_o, n;
   logic [31:0] reg_wdata_i, reg_rdata_o, d;
   logic [4:0] mb_qs_i, mbh_qscale_o, q;
   logic [3:0] bus_pending_i, burst, lat, fwd_horiz_range_o, fwd_vert_range_o, bwd_horiz_range_o, bwd_vert_range_o;
   logic [1:0] picture_type_o, picture_structure_o;
   vbd_cmd_e cmd_code_o;
   logic [3:0] codes [4] = '{4'h1, 4'h2, 4'h3, 4'h8};
   logic [7:0] offs [5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14};
   int n_errors = 0;
   int check_count = 0;
   int n_flush = 0;
   int nf, k;
   logic pz;
   vbd_ctrl u_dut (.*);
   vbd_partner u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_start_i(cmd_start_o), .allow_i(bus_start_allow_o),
      .burst_i(burst), .lat_i(lat), .pending_o(bus_pending_i), .done_o(dp_cmd_done_i));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (flush_start_o === 1'b1) n_flush++;
   function automatic logic [31:0] pp_rb(input logic [31:0] v);
      return v & ~32'h01f80000 & ~32'h00030000;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      cyc(1);
      reg_wr_i = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      cyc(1);
      reg_rd_i = 1'b0;
      cyc(1);
      chk(reg_rdata_o, e);
   endtask
   task automatic pulse_err(input logic sc);
      dp_start_code_present_i = sc;
      dp_error_i = 1'b1;
      cyc(1);
      dp_error_i = 1'b0;
      dp_start_code_present_i = 1'b0;
      cyc(1);
   endtask
   task automatic mbh(input logic v, input logic [4:0] c);
      mb_qs_valid_i = v;
      mb_qs_i = c;
      mb_header_i = 1'b1;
      cyc(1);
      mb_header_i = 1'b0;
      cyc(1);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      final_report();
   end
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, dp_error_i, dp_start_code_present_i, dp_start_code_i, dp_halt_i} = '0;
      {mb_header_i, mb_qs_valid_i, mb_qs_i, reg_addr_i, reg_wdata_i, burst, lat} = '0;
      void'($urandom(52));
      repeat (8) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      cyc(1);
      foreach (offs[i]) rd(offs[i], 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
         wr(VBD_OFF_PICTURE, d);
         chk(32'({picture_type_o, picture_structure_o, frame_only_flag_o, intra_table_select_o}), 32'(d[31:26]));
         chk(32'({fwd_horiz_range_o, fwd_vert_range_o, bwd_horiz_range_o, bwd_vert_range_o}), 32'(d[15:0]));
         chk(32'({standard_select_o, concealment_flag_o, parse_mb_pred_type_o}),
            32'({d[18], d[25] & d[18], d[18] & !d[27]}));
         rd(VBD_OFF_PICTURE, pp_rb(d));
      end
      $display("test picture parameters done");
      q = 5'($urandom);
      wr(VBD_OFF_SLICE_QS, 32'(q));
      chk(32'(mbh_qscale_o), 32'(q));
      mbh(1'b0, ~q);
      chk(32'(mbh_qscale_o), 32'(q));
      mbh(1'b1, ~q);
      chk(32'(mbh_qscale_o), 32'(q ^ 5'h1f));
      $display("test quantizer done");
      for (int i = 0; i < 2; i++) begin
         nf = n_flush;
         wr(VBD_OFF_CONTROL, 32'(i));
         pulse_err(i[0]);
         cyc(1);
         chk(32'(irq_o), 32'(i));
         rd(VBD_OFF_STATUS, i ? 32'h6 : 32'h4);
         chk(n_flush, nf);
         wr(VBD_OFF_STATUS, 32'h0);
         rd(VBD_OFF_STATUS, i ? 32'h6 : 32'h4);
         chk(32'(irq_o), 32'(i));
         wr(VBD_OFF_STATUS, 32'h4);
         chk(32'(irq_o), 32'h0);
         wr(VBD_OFF_STATUS, 32'h2);
         rd(VBD_OFF_STATUS, 32'h0);
      end
      $display("test error flags done");
      foreach (codes[i]) begin
         nf = n_flush;
         n = 8'($urandom);
         wr(VBD_OFF_COMMAND, {16'h0, n, 4'h0, codes[i]});
         chk(32'({cmd_code_o, cmd_count_o}), 32'({codes[i], n}));
         cyc(6);
         rd(VBD_OFF_STATUS, 32'h1);
         chk(n_flush, nf + (codes[i] == 4'h8));
      end
      $display("test commands done");
      for (int i = 0; i < 2; i++) begin
         wr(VBD_OFF_CONTROL, 32'h3);
         chk(32'(big_endian_o), 32'h1);
         wr(VBD_OFF_SLICE_QS, 32'h1f);
         wr(VBD_OFF_PICTURE, 32'hffffffff);
         pulse_err(1'b1);
         lat = 4'($urandom_range(7, 1));
         burst = i ? 4'h0 : 4'h3;
         cyc(1);
         burst = 4'h0;
         wr(VBD_OFF_COMMAND, 32'h4);
         chk(32'(bus_start_allow_o), 32'h0);
         k = 0;
         // Clear must follow the first quiet bus cycle, never come earlier or later
         while (buf_clear_o !== 1'b1 && k < 200) begin
            pz = (bus_pending_i == '0);
            cyc(1);
            chk(32'(buf_clear_o), 32'(pz));
            k++;
         end
         chk(32'({buf_clear_o, bus_pending_i, mbh_qscale_o, picture_type_o, big_endian_o}), 32'h1000);
         cyc(2);
         chk(32'({bus_start_allow_o, irq_o}), 32'h2);
         foreach (offs[j]) rd(offs[j], 32'h0);
      end
      $display("test software reset done");
      wr(VBD_OFF_SLICE_QS, 32'h1f);
      rst_n_i = 1'b0;
      #1 chk(32'({mbh_qscale_o, bus_start_allow_o}), 32'h1);
      cyc(2);
      rst_n_i = 1'b1;
      cyc(1);
      rd(VBD_OFF_SLICE_QS, 32'h0);
      $display("test hardware reset done");
      final_report();
   end
endmodule
bind vbd_ctrl vbd_ctrl_props #(.QS_W(QS_W), .PEND_W(PEND_W)) u_props (.*);
`default_nettype wire
